// >>> ontime_fault_pkg.sv
// Constants, field layouts and carrier types for the on-time modulation and fault timer core
//
// Contract
// - Upper switch on: on-time counter counts up in 10 ns units until comparator trips.
// - On trip turn upper off, wait dead time, then turn lower on.
// - Lower on: count down; at zero lower off and start dead time.
// - Upper turns on only after the post-lower dead time has fully elapsed.
// - Ignore on-time comparator for the blanking interval after each upper turn-on.
// - Comparator stuck active across cycles: reuse last valid on-time until normal trips return.
// - During startup soft-start output replaces the processed feedback set point.
// - Line feed-forward correction applied only while brownout input reports ok.
// - Filtered fault level enables fault timer; reaching confirm time confirms the fault.
// - Fault clear resets timer, or counts it down at own rate when cumulative.
// - Fault comparator passes a digital noise filter before reaching the timer.
// - Peak option and peak level reached: fault timer speeds up by configured factor.
// - Confirmed fault stops all driver pulses and enters protection; option picks handling.
// - Auto-recovery: wait fixed off-time, then restart through soft-start.
// - Latched: drivers stay off until supply reset level or line removal.
package ontime_fault_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned STEP_NS = 10;

	// Times in their own units and derived cycle counts
	localparam int unsigned DEAD_TIME_NS = 300;
	localparam int unsigned DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BLANKING_NS = 250;
	localparam int unsigned BLANK_CYCLES = (BLANKING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FILTER_NS = 1000;
	localparam int unsigned FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FAULT_CONFIRM_MS = 100;
	localparam int unsigned FAULT_CONFIRM_CYCLES = FAULT_CONFIRM_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned AUTO_RECOVERY_MS = 1000;
	localparam int unsigned AUTO_RECOVERY_CYCLES = AUTO_RECOVERY_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned SOFT_START_US = 5000;
	localparam int unsigned SOFT_START_CYCLES = SOFT_START_US * 1000 / CLK_PERIOD_NS;

	// On-time counter
	localparam int unsigned ONTIME_W = 12;
	localparam logic [11:0] ONTIME_MAX = 12'hFFF;
	localparam logic [11:0] ONTIME_INIT = 12'h064;

	// Register port
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_ONTIME = 8'h0C;
	localparam logic [7:0] REG_STATE = 8'h10;

	// Config field positions and reset value
	localparam int unsigned CFG_LATCHED_BIT = 0;
	localparam int unsigned CFG_CUMUL_BIT = 1;
	localparam int unsigned CFG_PEAK_EN_BIT = 2;
	localparam int unsigned CFG_FACTOR_LSB = 4;
	localparam int unsigned CFG_DOWN_LSB = 8;
	localparam logic [15:0] CONFIG_RESET = 16'h0140;

	// Status / mask event bits
	localparam int unsigned EV_FAULT_BIT = 0;
	localparam int unsigned EV_REPEAT_BIT = 1;
	localparam int unsigned EV_SATURATE_BIT = 2;
	localparam int unsigned EV_RESTART_BIT = 3;
	localparam int unsigned EV_W = 4;

	typedef struct packed {
		logic line_removed;
		logic supply_reset;
		logic brownout_ok;
		logic fault_peak;
		logic fault_level;
		logic ontime_trip;
	} comp_flags_t;

	typedef struct packed {
		logic [3:0] down_step;
		logic [3:0] peak_factor;
		logic peak_en;
		logic cumulative;
		logic latched;
	} fault_cfg_t;

	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_DEAD_PRE = 5'b00010,
		ST_UPPER = 5'b00100,
		ST_DEAD_POST = 5'b01000,
		ST_LOWER = 5'b10000
	} phase_t;

endpackage : ontime_fault_pkg

// >>> ontime_fault_core.sv
// On-time modulation, dead times, blanking and feedback fault timer core
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ontime_fault_core
	import ontime_fault_pkg::*;
#(
	parameter int unsigned FAULT_CONFIRM = FAULT_CONFIRM_CYCLES,
	parameter int unsigned AUTO_RECOVERY = AUTO_RECOVERY_CYCLES,
	parameter int unsigned SOFT_START = SOFT_START_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire comp_flags_t comp_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	output logic upper_drive_out,
	output logic lower_drive_out,
	output logic soft_start_select_out,
	output logic line_feed_forward_out,
	output logic protection_out,
	output logic irq_out
);

	// Converts 25 ns clock ticks into whole 10 ns steps, carrying the remainder
	function automatic logic [5:0] step_of(input logic [3:0] frac);
		logic [5:0] sum;
		logic [5:0] inc;
		logic [5:0] rem;
		sum = 6'(frac) + 6'(CLK_PERIOD_NS);
		inc = sum / 6'(STEP_NS);
		rem = sum % 6'(STEP_NS);
		step_of = {inc[1:0], rem[3:0]};
	endfunction : step_of

	// Unpacks a config word field by field; bit 3 is a hole, so a plain cast would misalign
	function automatic fault_cfg_t cfg_of(input logic [15:0] word);
		cfg_of = fault_cfg_t'({word[11:CFG_FACTOR_LSB], word[CFG_PEAK_EN_BIT],
			word[CFG_CUMUL_BIT], word[CFG_LATCHED_BIT]});
	endfunction : cfg_of

	// Two-flop synchronisers; first stage feeds only the second
	comp_flags_t sync1_r;
	comp_flags_t sync_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_r <= '0;
			sync_r <= '0;
		end else begin
			sync1_r <= comp_in;
			sync_r <= sync1_r;
		end
	end

	// Register state
	fault_cfg_t cfg_r, cfg_nxt;
	logic [EV_W-1:0] status_r, status_nxt;
	logic [EV_W-1:0] mask_r, mask_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [EV_W-1:0] events;

	// Switching state
	phase_t state_r, state_nxt;
	logic [11:0] ontime_r, ontime_nxt;
	logic [11:0] last_valid_r, last_valid_nxt;
	logic [3:0] frac_r, frac_nxt;
	logic [7:0] phase_cnt_r, phase_cnt_nxt;
	logic seen_low_r, seen_low_nxt;
	logic prot_r, prot_nxt;
	logic ss_active_r, ss_active_nxt;
	logic [31:0] slow_cnt_r, slow_cnt_nxt;

	// Fault path state
	logic filt_r, filt_nxt;
	logic [7:0] filt_cnt_r, filt_cnt_nxt;
	logic [31:0] timer_r, timer_nxt;
	logic confirm;

	// Noise filter: raw fault must hold its new level for the whole filter window
	always_comb begin
		filt_nxt = filt_r;
		filt_cnt_nxt = 8'h00;
		if (sync_r.fault_level != filt_r) begin
			if (filt_cnt_r == 8'(FILTER_CYCLES - 1)) begin
				filt_nxt = sync_r.fault_level;
			end else begin
				filt_cnt_nxt = filt_cnt_r + 8'h01;
			end
		end
	end

	// Fault timer: up while filtered fault, down or cleared otherwise
	always_comb begin
		logic [31:0] up;
		logic [31:0] down;
		up = 32'h0000_0001;
		down = 32'(cfg_r.down_step);
		confirm = 1'b0;
		timer_nxt = timer_r;
		if (cfg_r.peak_en && sync_r.fault_peak) begin
			up = 32'(cfg_r.peak_factor);
		end
		if (prot_r) begin
			timer_nxt = 32'h0000_0000;
		end else if (filt_r) begin
			timer_nxt = timer_r + up;
			if (timer_nxt >= 32'(FAULT_CONFIRM)) begin
				confirm = 1'b1;
			end
		end else if (cfg_r.cumulative) begin
			timer_nxt = (timer_r > down) ? timer_r - down : 32'h0000_0000;
		end else begin
			timer_nxt = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			filt_r <= 1'b0;
			filt_cnt_r <= 8'h00;
			timer_r <= 32'h0000_0000;
		end else begin
			filt_r <= filt_nxt;
			filt_cnt_r <= filt_cnt_nxt;
			timer_r <= timer_nxt;
		end
	end

	// Switching sequencer: dead time, upper, dead time, lower, with protection overriding all
	always_comb begin
		logic [5:0] st;
		logic [12:0] sum;
		logic blanked;
		logic trip;
		st = step_of(frac_r);
		sum = 13'(ontime_r) + 13'(st[5:4]);
		blanked = (phase_cnt_r < 8'(BLANK_CYCLES));
		trip = sync_r.ontime_trip && !blanked;
		state_nxt = state_r;
		ontime_nxt = ontime_r;
		last_valid_nxt = last_valid_r;
		frac_nxt = frac_r;
		phase_cnt_nxt = phase_cnt_r;
		seen_low_nxt = seen_low_r;
		prot_nxt = prot_r;
		ss_active_nxt = ss_active_r;
		slow_cnt_nxt = slow_cnt_r;
		events = '0;
		// Soft-start window counts up independently of the switching phase
		if (ss_active_r) begin
			if (slow_cnt_r >= 32'(SOFT_START - 1)) begin
				ss_active_nxt = 1'b0;
			end else begin
				slow_cnt_nxt = slow_cnt_r + 32'h0000_0001;
			end
		end
		unique case (state_r)
			ST_OFF: begin
				if (!prot_r) begin
					state_nxt = ST_DEAD_PRE;
					phase_cnt_nxt = 8'h00;
					ss_active_nxt = 1'b1;
					slow_cnt_nxt = 32'h0000_0000;
					events[EV_RESTART_BIT] = 1'b1;
				end else if (cfg_r.latched) begin
					if (sync_r.supply_reset || sync_r.line_removed) begin
						prot_nxt = 1'b0;
					end
				end else if (slow_cnt_r >= 32'(AUTO_RECOVERY - 1)) begin
					prot_nxt = 1'b0;
				end else begin
					slow_cnt_nxt = slow_cnt_r + 32'h0000_0001;
				end
			end
			ST_DEAD_PRE: begin
				phase_cnt_nxt = phase_cnt_r + 8'h01;
				if (phase_cnt_r == 8'(DEAD_CYCLES - 1)) begin
					state_nxt = ST_UPPER;
					ontime_nxt = 12'h000;
					frac_nxt = 4'h0;
					phase_cnt_nxt = 8'h00;
					seen_low_nxt = 1'b0;
				end
			end
			ST_UPPER: begin
				frac_nxt = st[3:0];
				ontime_nxt = (sum > 13'(ONTIME_MAX)) ? ONTIME_MAX : sum[11:0];
				if (blanked) begin
					phase_cnt_nxt = phase_cnt_r + 8'h01;
				end
				if (!blanked && !sync_r.ontime_trip) begin
					seen_low_nxt = 1'b1;
				end
				if (!blanked) begin
					if (trip && seen_low_r) begin
						state_nxt = ST_DEAD_POST;
						last_valid_nxt = ontime_r;
					end else if (trip && ontime_r >= last_valid_r) begin
						state_nxt = ST_DEAD_POST;
						ontime_nxt = last_valid_r;
						events[EV_REPEAT_BIT] = 1'b1;
					end else if (ontime_r == ONTIME_MAX) begin
						state_nxt = ST_DEAD_POST;
						events[EV_SATURATE_BIT] = 1'b1;
					end
					if (state_nxt == ST_DEAD_POST) begin
						phase_cnt_nxt = 8'h00;
						frac_nxt = 4'h0;
					end
				end
			end
			ST_DEAD_POST: begin
				phase_cnt_nxt = phase_cnt_r + 8'h01;
				if (phase_cnt_r == 8'(DEAD_CYCLES - 1)) begin
					state_nxt = ST_LOWER;
					phase_cnt_nxt = 8'h00;
				end
			end
			ST_LOWER: begin
				frac_nxt = st[3:0];
				if (ontime_r <= 12'(st[5:4])) begin
					ontime_nxt = 12'h000;
					state_nxt = ST_DEAD_PRE;
					phase_cnt_nxt = 8'h00;
				end else begin
					ontime_nxt = ontime_r - 12'(st[5:4]);
				end
			end
		endcase
		// Confirmed fault beats every phase and kills both drivers at once
		if (confirm) begin
			state_nxt = ST_OFF;
			prot_nxt = 1'b1;
			ss_active_nxt = 1'b0;
			slow_cnt_nxt = 32'h0000_0000;
			events[EV_FAULT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= ST_OFF;
			ontime_r <= 12'h000;
			last_valid_r <= ONTIME_INIT;
			frac_r <= 4'h0;
			phase_cnt_r <= 8'h00;
			seen_low_r <= 1'b0;
			prot_r <= 1'b0;
			ss_active_r <= 1'b0;
			slow_cnt_r <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			ontime_r <= ontime_nxt;
			last_valid_r <= last_valid_nxt;
			frac_r <= frac_nxt;
			phase_cnt_r <= phase_cnt_nxt;
			seen_low_r <= seen_low_nxt;
			prot_r <= prot_nxt;
			ss_active_r <= ss_active_nxt;
			slow_cnt_r <= slow_cnt_nxt;
		end
	end

	// Register port: writes, write-one-to-clear status, registered read data
	always_comb begin
		logic [EV_W-1:0] clr;
		cfg_nxt = cfg_r;
		mask_nxt = mask_r;
		clr = '0;
		rdata_nxt = 16'h0000;
		if (wr_in) begin
			unique case (addr_in)
				REG_CONFIG: cfg_nxt = cfg_of(wdata_in);
				REG_STATUS: clr = wdata_in[EV_W-1:0];
				REG_MASK: mask_nxt = wdata_in[EV_W-1:0];
				default: ;
			endcase
		end
		// Set wins over clear so an event in the clearing cycle survives
		status_nxt = (status_r & ~clr) | events;
		if (rd_in) begin
			unique case (addr_in)
				REG_CONFIG: rdata_nxt = {4'h0, cfg_r.down_step, cfg_r.peak_factor, 1'b0,
					cfg_r.peak_en, cfg_r.cumulative, cfg_r.latched};
				REG_STATUS: rdata_nxt = 16'(status_r);
				REG_MASK: rdata_nxt = 16'(mask_r);
				REG_ONTIME: rdata_nxt = 16'(last_valid_r);
				REG_STATE: rdata_nxt = {8'h00, filt_r, ss_active_r, prot_r, 5'(state_r)};
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_r <= cfg_of(CONFIG_RESET);
			status_r <= '0;
			mask_r <= '0;
			rdata_r <= 16'h0000;
		end else begin
			cfg_r <= cfg_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Drivers come straight from the one-hot phase flops, so they can never overlap
	assign upper_drive_out = state_r[2];
	assign lower_drive_out = state_r[4];
	assign soft_start_select_out = ss_active_r;
	assign line_feed_forward_out = sync_r.brownout_ok;
	assign protection_out = prot_r;
	assign rdata_out = rdata_r;
	assign irq_out = |(status_r & mask_r);

endmodule : ontime_fault_core
`default_nettype wire

// >>> ontime_fault_partner.sv
// Comparator model for the on-time trip
`timescale 1ns/1ps
`default_nettype none
module ontime_fault_partner (
	input wire logic clk_in,
	input wire logic upper_in,
	input wire logic stuck_in,
	input wire logic [11:0] delay_in,
	output logic trip_out
);
	logic [11:0] age_r = 12'h000;
	// Ramp age; an early spike probes the blanking window
	always_ff @(posedge clk_in) age_r <= upper_in ? age_r + 12'h001 : 12'h000;
	assign trip_out = stuck_in | (upper_in & (age_r == 12'h002 | age_r >= delay_in));
endmodule : ontime_fault_partner
`default_nettype wire

// >>> ontime_fault_monitor.sv
// Port checker for the on-time and fault core
`timescale 1ns/1ps
`default_nettype none
module ontime_fault_monitor
	import ontime_fault_pkg::*;
#(
	parameter int unsigned AUTO_RECOVERY = 300
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire comp_flags_t comp_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic upper_drive_out,
	input wire logic lower_drive_out,
	input wire logic soft_start_select_out,
	input wire logic line_feed_forward_out,
	input wire logic protection_out
);
	logic [11:0] idle_r, up_r, upl_r, lo_r, prot_r, flt_r;
	logic lat_r;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Run lengths; idle saturates so long stops cannot wrap
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			{idle_r, up_r, upl_r, lo_r, prot_r, flt_r} <= 72'h0;
			lat_r <= 1'b0;
		end else begin
			idle_r <= (upper_drive_out | lower_drive_out) ? 12'h000 : idle_r + {11'h0, ~&idle_r};
			up_r <= upper_drive_out ? up_r + 12'h001 : 12'h000;
			upl_r <= (!upper_drive_out && up_r != 12'h000) ? up_r : upl_r;
			lo_r <= lower_drive_out ? lo_r + 12'h001 : 12'h000;
			prot_r <= protection_out ? prot_r + 12'h001 : 12'h000;
			flt_r <= comp_in.fault_level ? flt_r + 12'h001 : 12'h000;
			if (wr_in && addr_in == REG_CONFIG)
				lat_r <= wdata_in[CFG_LATCHED_BIT];
		end
	end
	a_no_overlap: assert property (!(upper_drive_out && lower_drive_out))
		else $error("drivers overlap");
	a_dead_lower: assert property ($rose(lower_drive_out) |-> idle_r >= 12'h00C)
		else $error("short dead time");
	a_blank_hold: assert property ($rose(upper_drive_out) |-> (upper_drive_out || protection_out)[*8])
		else $error("upper ended in blanking");
	a_equal_halves: assert property ($fell(lower_drive_out) && !protection_out |->
		lo_r + 12'h002 >= upl_r && lo_r <= upl_r + 12'h002) else $error("halves differ");
	a_protect_off: assert property (protection_out |-> !upper_drive_out && !lower_drive_out)
		else $error("drive in protection");
	a_filter_first: assert property ($rose(protection_out) |-> flt_r >= 12'h028)
		else $error("fault not filtered");
	a_recover_wait: assert property ($fell(protection_out) && !lat_r |->
		prot_r + 12'h002 >= AUTO_RECOVERY ##[0:2] soft_start_select_out) else $error("bad recovery");
	a_feed_sync: assert property (line_feed_forward_out |-> $past(comp_in.brownout_ok, 2) ||
		$past(comp_in.brownout_ok, 3) || $past(comp_in.brownout_ok, 4)) else $error("feed-forward");
	c_fault: cover property ($rose(protection_out));
	c_lower: cover property ($rose(lower_drive_out));
	c_soft: cover property ($fell(soft_start_select_out));
endmodule : ontime_fault_monitor
bind ontime_fault_core ontime_fault_monitor #(.AUTO_RECOVERY(AUTO_RECOVERY)) ontime_fault_monitor_inst (
	.clk_in(clk_in), .rst_in(rst_in), .comp_in(comp_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .upper_drive_out(upper_drive_out),
	.lower_drive_out(lower_drive_out), .soft_start_select_out(soft_start_select_out),
	.line_feed_forward_out(line_feed_forward_out), .protection_out(protection_out));
`default_nettype wire

// >>> ontime_modulation_fault_timer_bench.sv
// Self-checking bench for the on-time and fault core
`timescale 1ns/1ps
`default_nettype none
module ontime_modulation_fault_timer_bench;
	import ontime_fault_pkg::*;
	localparam int unsigned AR = 300;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic stuck = 1'b0;
	logic [11:0] delay = 12'h028;
	logic [4:0] flags = 5'h04; // Line, supply, brownout, peak, level
	logic [15:0] rdata_out, rv;
	wire [5:0] outs; // Irq, protect, feed, soft, lower, upper
	wire trip;
	int bad_count = 0;
	int total_checks = 0;
	int n, m;
	ontime_fault_core #(.FAULT_CONFIRM(200), .AUTO_RECOVERY(AR), .SOFT_START(100)) ontime_fault_core_inst (
		.clk_in(clk_in), .rst_in(rst_in), .comp_in({flags, trip}), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.upper_drive_out(outs[0]), .lower_drive_out(outs[1]), .soft_start_select_out(outs[2]),
		.line_feed_forward_out(outs[3]), .protection_out(outs[4]), .irq_out(outs[5]));
	ontime_fault_partner ontime_fault_partner_inst (.clk_in(clk_in), .upper_in(outs[0]),
		.stuck_in(stuck), .delay_in(delay), .trip_out(trip));
	initial forever #12.5 clk_in = ~clk_in;
	task automatic ok(input logic c);
		total_checks++;
		if (c !== 1'b1) begin
			bad_count++;
			$display("Error t=%0t check failed", $time);
		end
	endtask : ok
	// Bounded wait; sampled 1 ns after the edge to avoid races
	task automatic await(input int i, input logic v, input int lim);
		n = 0;
		while (outs[i] !== v && n < lim) begin
			@(posedge clk_in);
			#1;
			n++;
		end
	endtask : await
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		rv = rdata_out;
	endtask : rd
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_in);
		bad_count++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(REG_CONFIG);
		ok(rv === CONFIG_RESET);
		rd(REG_ONTIME);
		ok(rv === {4'h0, ONTIME_INIT});
		wr(8'h14, 16'hFFFF);
		rd(8'h14);
		ok(rv === 16'h0000);
		rd(REG_STATUS);
		ok(rv === 16'h0008 && outs[2] === 1'b1);
		$display("registers done");
		await(0, 1'b0, 200);
		await(0, 1'b1, 200);
		await(0, 1'b0, 200);
		m = n;
		ok(m >= 41 && m <= 47);
		await(1, 1'b1, 50);
		ok(n == 12);
		await(1, 1'b0, 200);
		ok(n + 1 >= m && n <= m + 1);
		await(0, 1'b1, 50);
		ok(n == 12);
		$display("switching done");
		@(posedge clk_in) stuck <= 1'b1;
		await(0, 1'b0, 200);
		await(0, 1'b1, 200);
		await(0, 1'b0, 200);
		ok(n + 2 >= m && n <= m + 2);
		wr(REG_MASK, 16'h0002);
		ok(outs[5] === 1'b1);
		@(posedge clk_in) stuck <= 1'b0;
		repeat (2) begin
			await(0, 1'b1, 200);
			await(0, 1'b0, 200);
		end
		wr(REG_STATUS, 16'h0002);
		ok(outs[5] === 1'b0);
		$display("repeat done");
		@(posedge clk_in) delay <= 12'hFFF;
		await(0, 1'b1, 200);
		await(0, 1'b0, 2000);
		ok(n >= 1630 && n <= 1645);
		rd(REG_STATUS);
		ok(rv[2] === 1'b1 && outs[5] === 1'b0);
		@(posedge clk_in) delay <= 12'h028;
		wr(REG_STATUS, 16'h000F);
		$display("saturation done");
		@(posedge clk_in) flags <= 5'h00;
		await(3, 1'b0, 6);
		ok(outs[3] === 1'b0);
		@(posedge clk_in) flags <= 5'h04;
		await(3, 1'b1, 6);
		ok(outs[3] === 1'b1);
		@(posedge clk_in) flags <= 5'h05;
		repeat (38) @(posedge clk_in);
		flags <= 5'h04;
		rd(REG_STATE);
		ok(rv[7] === 1'b0);
		repeat (100) @(posedge clk_in);
		ok(outs[4] === 1'b0);
		@(posedge clk_in) flags <= 5'h05;
		await(4, 1'b1, 400);
		ok(n >= 235 && n <= 255 && outs[1:0] === 2'b00);
		@(posedge clk_in) flags <= 5'h04;
		await(4, 1'b0, 400);
		ok(n >= AR - 5);
		await(2, 1'b1, 3);
		ok(outs[2] === 1'b1);
		$display("auto fault done");
		wr(REG_CONFIG, 16'h0144);
		@(posedge clk_in) flags <= 5'h07;
		await(4, 1'b1, 400);
		ok(n >= 85 && n <= 105);
		@(posedge clk_in) flags <= 5'h04;
		await(4, 1'b0, 400);
		// Cumulative timer counts down by one per cycle across a short clear instead of resetting
		wr(REG_CONFIG, 16'h0143);
		@(posedge clk_in) flags <= 5'h05;
		repeat (140) @(posedge clk_in);
		flags <= 5'h04;
		repeat (60) @(posedge clk_in);
		flags <= 5'h05;
		await(4, 1'b1, 400);
		ok(n < 220);
		@(posedge clk_in) flags <= 5'h04;
		repeat (AR + 50) @(posedge clk_in);
		ok(outs[4] === 1'b1);
		flags <= 5'h0C;
		repeat (3) @(posedge clk_in);
		flags <= 5'h04;
		await(4, 1'b0, 10);
		ok(outs[4] === 1'b0);
		// Second latched fault, released by line removal instead of supply reset
		@(posedge clk_in) flags <= 5'h05;
		await(4, 1'b1, 400);
		ok(outs[4] === 1'b1);
		@(posedge clk_in) flags <= 5'h04;
		repeat (AR) @(posedge clk_in);
		ok(outs[4] === 1'b1);
		flags <= 5'h14;
		repeat (3) @(posedge clk_in);
		flags <= 5'h04;
		await(4, 1'b0, 10);
		ok(outs[4] === 1'b0);
		$display("latched fault done");
		results();
	end
endmodule : ontime_modulation_fault_timer_bench
`default_nettype wire
